// [distributed_dma_pkg.sv]
/*
  Shared constants and types for the distributed dma slave channel:
  register indices, field positions, reset values and carrier structs.
  Assumes a single 25 MHz clock domain and word-aligned AHB-Lite access.
*/
package distributed_dma_pkg;

  // register indices; byte address is four times the index
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_ADDRESS  = 6'h00;
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_PAGE     = 6'h02;
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_COUNT    = 6'h04;
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_CMD_STAT = 6'h08;
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_SW_REQ   = 6'h09;
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_MODE     = 6'h0B;
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_CLEAR    = 6'h0D;
  localparam logic [5:0] DISTRIBUTED_DMA_IDX_MASK     = 6'h0F;

  // field positions
  localparam int DISTRIBUTED_DMA_MODE_SEL_HI  = 7;
  localparam int DISTRIBUTED_DMA_MODE_SEL_LO  = 6;
  localparam int DISTRIBUTED_DMA_MODE_DIR     = 5;
  localparam int DISTRIBUTED_DMA_MODE_AUTO    = 4;
  localparam int DISTRIBUTED_DMA_MODE_TYPE_HI = 3;
  localparam int DISTRIBUTED_DMA_MODE_TYPE_LO = 2;
  localparam int DISTRIBUTED_DMA_CMD_DISABLE  = 2;
  localparam int DISTRIBUTED_DMA_MASK_BIT     = 0;

  // reset values
  localparam logic [7:0]  DISTRIBUTED_DMA_MODE_RST    = 8'h00;
  localparam logic        DISTRIBUTED_DMA_CMD_DIS_RST = 1'b0;
  localparam logic        DISTRIBUTED_DMA_MASK_RST    = 1'b1;
  localparam logic [15:0] DISTRIBUTED_DMA_WORD_RST    = 16'h0000;
  localparam logic [7:0]  DISTRIBUTED_DMA_PAGE_RST    = 8'h00;

  // count steps per transfer width
  localparam logic [15:0] DISTRIBUTED_DMA_STEP_NARROW = 16'h0001;
  localparam logic [15:0] DISTRIBUTED_DMA_STEP_WIDE   = 16'h0002;

  // ahb-lite encodings
  localparam logic [1:0] DISTRIBUTED_DMA_HTRANS_NONSEQ = 2'h2;
  localparam logic [1:0] DISTRIBUTED_DMA_HTRANS_SEQ    = 2'h3;

  typedef enum logic [1:0] {
    DISTRIBUTED_DMA_MODE_DEMAND = 2'h0,
    DISTRIBUTED_DMA_MODE_SINGLE = 2'h1,
    DISTRIBUTED_DMA_MODE_BLOCK  = 2'h2,
    DISTRIBUTED_DMA_MODE_RSVD   = 2'h3
  } distributed_dma_mode_t;

  typedef enum logic [1:0] {
    DISTRIBUTED_DMA_TYPE_NONE  = 2'h0,
    DISTRIBUTED_DMA_TYPE_WRITE = 2'h1,
    DISTRIBUTED_DMA_TYPE_READ  = 2'h2,
    DISTRIBUTED_DMA_TYPE_RSVD  = 2'h3
  } distributed_dma_type_t;

  // software write strobes into the address/count datapath
  typedef struct packed {
    logic        address_we;
    logic        page_we;
    logic        count_we;
    logic [15:0] data;
  } distributed_dma_wr_t;

  // state presented to the transfer engine
  typedef struct packed {
    logic        request;
    distributed_dma_mode_t  mode;
    distributed_dma_type_t  xtype;
    logic        descending;
    logic [7:0]  page;
    logic [15:0] address;
    logic [15:0] count;
  } distributed_dma_xfer_t;

endpackage

// [distributed_dma_addr_count.sv]
/*
  Address and count datapath of the channel: base and current values,
  stepping after each transfer, terminal count and auto reload.
  Assumes i_clear is high for the cycle of any reset of the channel.
*/
`timescale 1ns/1ps
module distributed_dma_addr_count
  import distributed_dma_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_clear,
  input  wire distributed_dma_wr_t    i_wr,
  input  wire logic        i_done,
  input  wire logic        i_wide,
  input  wire logic        i_descending,
  input  wire logic        i_auto_reload,
  output logic [15:0]      o_address,
  output logic [7:0]       o_page,
  output logic [15:0]      o_count,
  output logic             o_terminal
);

  logic [15:0] base_addr_q, base_addr_d;
  logic [15:0] cur_addr_q,  cur_addr_d;
  logic [15:0] base_cnt_q,  base_cnt_d;
  logic [15:0] cur_cnt_q,   cur_cnt_d;
  logic [7:0]  page_q,      page_d;
  logic        tc_q,        tc_d;
  logic [15:0] step;

  //////////////////////////////////////////////////////////////////////////
  // next values
  always_comb begin
    step        = i_wide ? DISTRIBUTED_DMA_STEP_WIDE : DISTRIBUTED_DMA_STEP_NARROW;
    base_addr_d = base_addr_q;
    cur_addr_d  = cur_addr_q;
    base_cnt_d  = base_cnt_q;
    cur_cnt_d   = cur_cnt_q;
    page_d      = page_q;
    tc_d        = 1'b0;
    if (i_wr.address_we) begin
      base_addr_d = i_wr.data;
      cur_addr_d  = i_wr.data;
    end
    if (i_wr.page_we) begin
      page_d = i_wr.data[7:0];
    end
    if (i_wr.count_we) begin
      base_cnt_d = i_wr.data;
      cur_cnt_d  = i_wr.data;
    end
    if (i_done) begin
      // step after each transfer
      cur_addr_d = i_descending ? cur_addr_q - 16'h0001 : cur_addr_q + 16'h0001;
      cur_cnt_d  = (cur_cnt_q > step) ? cur_cnt_q - step : 16'h0000;
      // count used up on this transfer
      if (cur_cnt_q <= step) begin
        tc_d = 1'b1;
        if (i_auto_reload) begin
          cur_addr_d = base_addr_q;
          cur_cnt_d  = base_cnt_q;
        end
      end
    end
  end

  // registers only; clear covers both reset and controller clear
  always_ff @(posedge i_mclk) begin
    if (i_clear) begin
      base_addr_q <= DISTRIBUTED_DMA_WORD_RST;
      cur_addr_q  <= DISTRIBUTED_DMA_WORD_RST;
      base_cnt_q  <= DISTRIBUTED_DMA_WORD_RST;
      cur_cnt_q   <= DISTRIBUTED_DMA_WORD_RST;
      page_q      <= DISTRIBUTED_DMA_PAGE_RST;
      tc_q        <= 1'b0;
    end else begin
      base_addr_q <= base_addr_d;
      cur_addr_q  <= cur_addr_d;
      base_cnt_q  <= base_cnt_d;
      cur_cnt_q   <= cur_cnt_d;
      page_q      <= page_d;
      tc_q        <= tc_d;
    end
  end

  assign o_address  = cur_addr_q;
  assign o_page     = page_q;
  assign o_count    = cur_cnt_q;
  assign o_terminal = tc_q;

endmodule

// [distributed_dma_channel.sv]
/*
  Distributed dma slave channel: AHB-Lite register slave, mode, mask and
  status logic, and the request to the transfer engine.
  The address and count datapath sits in distributed_dma_addr_count; this file owns
  the bus decode, the mode, command and mask registers, the status flags
  and the request level handed to the transfer engine.
  Assumes card inputs are synchronous to i_mclk and that the transfer
  engine pulses i_xfer_done once per completed transfer.
  Assumes hready is looped back from hreadyout, this being the only slave,
  and that every transfer is a whole word; hsize is not checked.
*/
// Functional notes
// - request status bits mirror card request
// - request status ignores the mask bit
// - terminal count sets all four bits
// - status read or reset clears terminal count
// - in block mode any software request write starts transfer
// - mode field picks demand, single, block
// - direction bit steps address up or down
// - mode bit four enables auto reload
// - type field picks none, write, read
// - controller clear write resets all registers
// - mask register holds only bit zero
// - card removal sets the mask bit
// - set mask ignores card requests
// - mask bit resets to one
// - mode bits one, zero read zero
// - count drops one or two per transfer
// - command bit two disables the controller
`timescale 1ns/1ps
module distributed_dma_channel
  import distributed_dma_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset,
  // ahb-lite slave
  input  wire logic        i_hsel,
  input  wire logic [7:0]  i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic [31:0]      o_hrdata,
  output logic             o_hreadyout,
  output logic             o_hresp,
  // card side
  input  wire logic        i_card_dma_request,
  input  wire logic        i_card_present,
  // transfer engine side
  input  wire logic        i_xfer_done,
  input  wire logic        i_wide_mode,
  output distributed_dma_xfer_t       o_xfer,
  output logic             o_terminal_count
);

  //////////////////////////////////////////////////////////////////////////
  // bus front end
  //
  // register map, byte address is four times the index:
  //   0x00 address, base on write, current on read
  //   0x08 page, upper address byte
  //   0x10 count, base on write, current on read
  //   0x20 command on write, status on read
  //   0x24 software request, write only
  //   0x2C transfer mode, bits one and zero read zero
  //   0x34 controller clear, write only
  //   0x3C request mask, bit zero only
  //   any other index reads zero and drops writes
  // a write lands at the end of its data phase with no wait state; a read
  // takes one wait state so a write just before it is already visible

  typedef enum {DISTRIBUTED_DMA_BUS_IDLE, DISTRIBUTED_DMA_BUS_WRITE, DISTRIBUTED_DMA_BUS_RD_WAIT, DISTRIBUTED_DMA_BUS_RD_DONE} distributed_dma_bus_t;

  distributed_dma_bus_t   bus_q, bus_d;
  logic [5:0]  idx_q, idx_d;
  logic [31:0] rdata_q, rdata_d;
  logic        take;

  // a whole-word single transfer addressed to us
  // only NONSEQ and SEQ count; IDLE and BUSY are ignored
  assign take = i_hsel && i_hready && (i_htrans == DISTRIBUTED_DMA_HTRANS_NONSEQ || i_htrans == DISTRIBUTED_DMA_HTRANS_SEQ);

  // byte address to register index
  function automatic logic [5:0] distributed_dma_index(input logic [7:0] addr);
    distributed_dma_index = addr[7:2];
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // channel state

  logic [7:0] mode_q, mode_d;
  logic       cmd_dis_q, cmd_dis_d;
  logic       mask_q, mask_d;
  logic       tc_flag_q, tc_flag_d;
  logic       sw_req_q, sw_req_d;
  logic       present_q;
  logic       wr_en, rd_status;
  logic       clear_now;
  logic       dp_terminal;
  logic [15:0] dp_addr, dp_count;
  logic [7:0]  dp_page;
  distributed_dma_wr_t   dp_wr;
  logic [7:0] status_byte;
  logic       card_removed;
  logic       engine_step;
  logic       engine_on;
  logic       type_valid;
  logic       card_wants;
  logic       soft_wants;

  // register write is applied in the data phase
  assign wr_en = (bus_q == DISTRIBUTED_DMA_BUS_WRITE);
  // status read side effect happens once, in the wait state where the
  // status byte is captured, so the read still returns the flags
  assign rd_status = (bus_q == DISTRIBUTED_DMA_BUS_RD_WAIT) && idx_q == DISTRIBUTED_DMA_IDX_CMD_STAT;

  // write of any value clears the whole controller
  assign clear_now = i_reset || (wr_en && idx_q == DISTRIBUTED_DMA_IDX_CLEAR);

  // request status copies the card line, mask not involved
  assign status_byte = {{4{i_card_dma_request}}, {4{tc_flag_q}}};

  // falling edge of presence marks a removal
  assign card_removed = present_q && !i_card_present;

  // shared enable and type decode for stepping and the request
  assign engine_on  = !cmd_dis_q;
  assign type_valid = mode_q[DISTRIBUTED_DMA_MODE_TYPE_HI:DISTRIBUTED_DMA_MODE_TYPE_LO] == DISTRIBUTED_DMA_TYPE_WRITE
                      || mode_q[DISTRIBUTED_DMA_MODE_TYPE_HI:DISTRIBUTED_DMA_MODE_TYPE_LO] == DISTRIBUTED_DMA_TYPE_READ;

  // a done pulse steps the datapath only while enabled with a real type,
  // so a stray pulse while disabled or with no type cannot move address or count; a masked one still can
  assign engine_step = i_xfer_done && engine_on && type_valid;

  // masked card requests are dropped; software asks only in block mode
  assign card_wants = i_card_dma_request && !mask_q;
  assign soft_wants = sw_req_q && mode_q[DISTRIBUTED_DMA_MODE_SEL_HI:DISTRIBUTED_DMA_MODE_SEL_LO] == DISTRIBUTED_DMA_MODE_BLOCK;

  // bus sequencer and read mux
  always_comb begin
    bus_d   = bus_q;
    idx_d   = idx_q;
    rdata_d = rdata_q;
    case (bus_q)
      DISTRIBUTED_DMA_BUS_IDLE, DISTRIBUTED_DMA_BUS_WRITE, DISTRIBUTED_DMA_BUS_RD_DONE: begin
        bus_d = DISTRIBUTED_DMA_BUS_IDLE;
        if (take) begin
          idx_d = distributed_dma_index(i_haddr);
          bus_d = i_hwrite ? DISTRIBUTED_DMA_BUS_WRITE : DISTRIBUTED_DMA_BUS_RD_WAIT;
        end
      end
      DISTRIBUTED_DMA_BUS_RD_WAIT: begin
        // one wait state so a preceding write is already visible
        bus_d   = DISTRIBUTED_DMA_BUS_RD_DONE;
        rdata_d = 32'h0000_0000;
        // unmapped and write-only indices read zero
        case (idx_q)
          DISTRIBUTED_DMA_IDX_ADDRESS:  rdata_d = {16'h0000, dp_addr};
          DISTRIBUTED_DMA_IDX_PAGE:     rdata_d = {24'h000000, dp_page};
          DISTRIBUTED_DMA_IDX_COUNT:    rdata_d = {16'h0000, dp_count};
          DISTRIBUTED_DMA_IDX_CMD_STAT: rdata_d = {24'h000000, status_byte};
          DISTRIBUTED_DMA_IDX_MODE:     rdata_d = {24'h000000, mode_q[7:2], 2'b00};
          DISTRIBUTED_DMA_IDX_MASK:     rdata_d = {31'h00000000, mask_q};
          default:           rdata_d = 32'h0000_0000;
        endcase
      end
      default: bus_d = DISTRIBUTED_DMA_BUS_IDLE;
    endcase
  end

  // bus state; a controller clear leaves it alone so the clear write
  // itself still completes its data phase
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      bus_q   <= DISTRIBUTED_DMA_BUS_IDLE;
      idx_q   <= 6'h00;
      rdata_q <= 32'h0000_0000;
    end else begin
      bus_q   <= bus_d;
      idx_q   <= idx_d;
      rdata_q <= rdata_d;
    end
  end

  // hreadyout drops only in the read wait state; hresp is always OKAY
  // and read data stands until the next read completes
  assign o_hreadyout = (bus_q != DISTRIBUTED_DMA_BUS_RD_WAIT);
  assign o_hresp     = 1'b0;
  assign o_hrdata    = rdata_q;

  //////////////////////////////////////////////////////////////////////////
  // mode, command, mask, status flags

  always_comb begin
    mode_d    = mode_q;
    cmd_dis_d = cmd_dis_q;
    mask_d    = mask_q;
    tc_flag_d = tc_flag_q;
    sw_req_d  = sw_req_q;
    // software writes, applied in the data phase
    if (wr_en) begin
      case (idx_q)
        DISTRIBUTED_DMA_IDX_MODE:     mode_d    = {i_hwdata[7:2], 2'b00};
        DISTRIBUTED_DMA_IDX_CMD_STAT: cmd_dis_d = i_hwdata[DISTRIBUTED_DMA_CMD_DISABLE];
        DISTRIBUTED_DMA_IDX_MASK:     mask_d    = i_hwdata[DISTRIBUTED_DMA_MASK_BIT];
        DISTRIBUTED_DMA_IDX_SW_REQ:   sw_req_d  = 1'b1;
        default:           mode_d    = mode_q;
      endcase
    end
    // removal sets the mask and wins over a same-cycle write
    if (card_removed) begin
      mask_d = 1'b1;
    end
    // read clears terminal count, a new terminal count wins
    if (rd_status) begin
      tc_flag_d = 1'b0;
    end
    // terminal count ends a software request; it must be written again
    // for the next block
    if (dp_terminal) begin
      tc_flag_d = 1'b1;
      sw_req_d  = 1'b0;
    end
  end

  // registers; reset and a controller clear share one path, and the mask
  // comes back set so card requests wait for software
  always_ff @(posedge i_mclk) begin
    if (clear_now) begin
      mode_q    <= DISTRIBUTED_DMA_MODE_RST;
      cmd_dis_q <= DISTRIBUTED_DMA_CMD_DIS_RST;
      mask_q    <= DISTRIBUTED_DMA_MASK_RST;
      tc_flag_q <= 1'b0;
      sw_req_q  <= 1'b0;
    end else begin
      mode_q    <= mode_d;
      cmd_dis_q <= cmd_dis_d;
      mask_q    <= mask_d;
      tc_flag_q <= tc_flag_d;
      sw_req_q  <= sw_req_d;
    end
  end

  // presence history for removal edge; zero after reset so no false removal follows it
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      present_q <= 1'b0;
    end else begin
      present_q <= i_card_present;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // address and count datapath

  // software writes into the datapath; address and count take the low
  // half of the data word, page the low byte
  always_comb begin
    dp_wr.address_we = wr_en && idx_q == DISTRIBUTED_DMA_IDX_ADDRESS;
    dp_wr.page_we    = wr_en && idx_q == DISTRIBUTED_DMA_IDX_PAGE;
    dp_wr.count_we   = wr_en && idx_q == DISTRIBUTED_DMA_IDX_COUNT;
    dp_wr.data       = i_hwdata[15:0];
  end

  // datapath clears together with the rest of the channel
  distributed_dma_addr_count distributed_dma_addr_count_i (
    .i_mclk        (i_mclk),
    .i_clear       (clear_now),
    .i_wr          (dp_wr),
    .i_done        (engine_step),
    .i_wide        (i_wide_mode),
    .i_descending  (mode_q[DISTRIBUTED_DMA_MODE_DIR]),
    .i_auto_reload (mode_q[DISTRIBUTED_DMA_MODE_AUTO]),
    .o_address     (dp_addr),
    .o_page        (dp_page),
    .o_count       (dp_count),
    .o_terminal    (dp_terminal)
  );

  //////////////////////////////////////////////////////////////////////////
  // request toward the transfer engine

  // level handed to the engine together with the fields it needs;
  // the request is combinational so a mask write takes effect at once
  always_comb begin
    o_xfer.mode       = distributed_dma_mode_t'(mode_q[DISTRIBUTED_DMA_MODE_SEL_HI:DISTRIBUTED_DMA_MODE_SEL_LO]);
    o_xfer.xtype      = distributed_dma_type_t'(mode_q[DISTRIBUTED_DMA_MODE_TYPE_HI:DISTRIBUTED_DMA_MODE_TYPE_LO]);
    o_xfer.descending = mode_q[DISTRIBUTED_DMA_MODE_DIR];
    o_xfer.page       = dp_page;
    o_xfer.address    = dp_addr;
    o_xfer.count      = dp_count;
    // masked card requests ignored; disabled controller or no type asks nothing
    o_xfer.request    = engine_on
                        && type_valid
                        && o_xfer.mode != DISTRIBUTED_DMA_MODE_RSVD
                        && (card_wants || soft_wants);
  end

  // one-cycle pulse, a cycle after the done that used the count up
  assign o_terminal_count = dp_terminal;

endmodule

// [distributed_dma_channel_sva.sv]
/*
  Port checker for the dma slave channel.
  Assumes one clock and a bind onto distributed_dma_channel.
*/
`timescale 1ns/1ps
module distributed_dma_channel_sva
  import distributed_dma_pkg::*;
(
  input wire logic        i_mclk,
  input wire logic        i_reset,
  input wire logic        i_hsel,
  input wire logic [7:0]  i_haddr,
  input wire logic [1:0]  i_htrans,
  input wire logic        i_hwrite,
  input wire logic        i_hready,
  input wire logic        o_hreadyout,
  input wire logic        i_card_dma_request,
  input wire logic        i_card_present,
  input wire logic        i_xfer_done,
  input wire logic        i_wide_mode,
  input wire distributed_dma_xfer_t  o_xfer,
  input wire logic        o_terminal_count
);
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  logic take;
  logic step;
  // accepted address phase; a mid-block step that cannot be a reload
  assign take = i_hsel && i_hready && i_htrans[1];
  assign step = i_xfer_done && o_xfer.request && o_xfer.count > 16'h0002;
  ////////////////////////////////////////////////////////////
  AST_RD_WAIT: assert property (take && !i_hwrite |=> !o_hreadyout ##1 o_hreadyout)
    else $error("read wait state wrong");
  AST_CLEAR: assert property (take && i_hwrite && i_haddr[7:2] == DISTRIBUTED_DMA_IDX_CLEAR |-> ##2
    (o_xfer.mode == DISTRIBUTED_DMA_MODE_DEMAND && o_xfer.xtype == DISTRIBUTED_DMA_TYPE_NONE && !o_xfer.request))
    else $error("clear left state");
  AST_RST_VAL: assert property ($fell(i_reset) |-> !o_xfer.descending && o_xfer.count == 16'h0000)
    else $error("reset values wrong");
  AST_TC_ONE: assert property (o_terminal_count |=> !o_terminal_count)
    else $error("terminal pulse too long");
  AST_TC_CAUSE: assert property (o_terminal_count |-> $past(i_xfer_done))
    else $error("terminal without transfer");
  AST_TYPE0: assert property (o_xfer.xtype == DISTRIBUTED_DMA_TYPE_NONE |-> !o_xfer.request)
    else $error("request with no type");
  AST_RSVD: assert property (o_xfer.mode == DISTRIBUTED_DMA_MODE_RSVD |-> !o_xfer.request)
    else $error("request in reserved mode");
  AST_REQ_SRC: assert property (o_xfer.request |-> i_card_dma_request || o_xfer.mode == DISTRIBUTED_DMA_MODE_BLOCK)
    else $error("request without source");
  AST_REMOVE: assert property ($fell(i_card_present) && o_xfer.mode != DISTRIBUTED_DMA_MODE_BLOCK |=> !o_xfer.request)
    else $error("removal did not mask");
  AST_COUNT: assert property (step |=> o_xfer.count == $past(o_xfer.count) -
    ($past(i_wide_mode) ? DISTRIBUTED_DMA_STEP_WIDE : DISTRIBUTED_DMA_STEP_NARROW)) else $error("count step wrong");
  AST_ADDR: assert property (step |=> o_xfer.address == ($past(o_xfer.descending) ?
    $past(o_xfer.address) - 16'h0001 : $past(o_xfer.address) + 16'h0001)) else $error("address step wrong");
endmodule
bind distributed_dma_channel distributed_dma_channel_sva distributed_dma_channel_sva_i (.i_mclk, .i_reset, .i_hsel, .i_haddr, .i_htrans,
  .i_hwrite, .i_hready, .o_hreadyout, .i_card_dma_request, .i_card_present, .i_xfer_done, .i_wide_mode,
  .o_xfer, .o_terminal_count);

// [distributed_dma_engine_model.sv]
/*
  Transfer engine stand-in: a done pulse per DELAY cycles of request.
  Assumes the request level shares the channel clock.
*/
`timescale 1ns/1ps
module distributed_dma_engine_model
#(
  parameter int DELAY = 4
)
(
  input  wire logic i_mclk,
  input  wire logic i_reset,
  input  wire logic i_request,
  output logic      o_done
);
  logic [7:0] cnt_q;
  logic [7:0] cnt_d;
  logic       done_d;
  // slow enough that a dropped request never earns a stray pulse
  always_comb begin
    done_d = i_request && (cnt_q == 8'(DELAY - 1));
    cnt_d = (i_request && !done_d) ? cnt_q + 8'h01 : 8'h00;
  end
  ////////////////////////////////////////////////////////////
  always_ff @(posedge i_mclk) begin
    cnt_q <= i_reset ? 8'h00 : cnt_d;
    o_done <= i_reset ? 1'b0 : done_d;
  end
endmodule

// [distributed_dma_channel_bench.sv]
/*
  Self-checking bench for the channel over AHB-Lite.
  Assumes the engine model answers requests.
*/
`timescale 1ns/1ps
module distributed_dma_channel_bench
  import distributed_dma_pkg::*;
;
  logic        mclk = 1'b0;
  logic        rst = 1'b1;
  logic        hsel = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        card_req = 1'b0;
  logic        card_pres = 1'b1;
  logic        wide = 1'b0;
  logic [31:0] hrdata;
  logic        hready;
  logic        tc;
  logic        done;
  distributed_dma_xfer_t  xfer;
  int          num_errors = 0;
  int          compares = 0;
  always #20 mclk = ~mclk;
  distributed_dma_channel distributed_dma_channel_i (.i_mclk(mclk), .i_reset(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hready),
    .o_hrdata(hrdata), .o_hreadyout(hready), .o_hresp(), .i_card_dma_request(card_req),
    .i_card_present(card_pres), .i_xfer_done(done), .i_wide_mode(wide), .o_xfer(xfer), .o_terminal_count(tc));
  distributed_dma_engine_model distributed_dma_engine_model_i (.i_mclk(mclk), .i_reset(rst), .i_request(xfer.request), .o_done(done));
  ////////////////////////////////////////////////////////////
  task automatic test_done();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  // one single transfer; read data taken at the closing hready edge
  task automatic bus(input logic w, input logic [5:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge mclk);
    hsel <= 1'b1;
    htrans <= DISTRIBUTED_DMA_HTRANS_NONSEQ;
    hwrite <= w;
    haddr <= {idx, 2'b00};
    do @(posedge mclk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge mclk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [5:0] idx, input logic [31:0] wd);
    logic [31:0] rd;
    bus(1'b1, idx, wd, rd);
  endtask
  task automatic rd(input logic [5:0] idx, input logic [31:0] e);
    logic [31:0] v;
    bus(1'b0, idx, 32'h0, v);
    chk(v, e);
  endtask
  // count engine pulses up to the terminal pulse, then drop the card
  task automatic wait_tc(input int e);
    int n;
    bit seen;
    n = 0;
    seen = 0;
    repeat (60) begin
      @(posedge mclk);
      if (!seen && done === 1'b1) n++;
      if (!seen && tc === 1'b1) begin
        seen = 1;
        card_req <= 1'b0;
      end
    end
    chk(32'(seen), 32'h1);
    chk(32'(n), 32'(e));
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(DISTRIBUTED_DMA_IDX_MODE, 32'h0);
    rd(DISTRIBUTED_DMA_IDX_MASK, 32'h1);
    rd(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'h0);
    rd(6'h01, 32'h0);
  endtask
  task automatic t_reserved();
    wr(DISTRIBUTED_DMA_IDX_MASK, 32'hFF);
    rd(DISTRIBUTED_DMA_IDX_MASK, 32'h1);
    wr(DISTRIBUTED_DMA_IDX_MASK, 32'hFE);
    rd(DISTRIBUTED_DMA_IDX_MASK, 32'h0);
    wr(DISTRIBUTED_DMA_IDX_MODE, 32'hFF);
    rd(DISTRIBUTED_DMA_IDX_MODE, 32'hFC);
  endtask
  task automatic t_card();
    wr(DISTRIBUTED_DMA_IDX_MASK, 32'h1);
    card_req <= 1'b1;
    wr(DISTRIBUTED_DMA_IDX_MODE, 32'h44);
    rd(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'hF0);
    chk(32'(xfer.request), 32'h0);
    wr(DISTRIBUTED_DMA_IDX_MASK, 32'h0);
    #1 chk(32'(xfer.request), 32'h1);
    wr(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'h04);
    #1 chk(32'(xfer.request), 32'h0);
    wr(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'h00);
    card_req <= 1'b0;
    rd(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'h0);
  endtask
  task automatic t_block();
    wr(DISTRIBUTED_DMA_IDX_MODE, 32'hA4);
    wr(DISTRIBUTED_DMA_IDX_ADDRESS, 32'h10);
    wr(DISTRIBUTED_DMA_IDX_COUNT, 32'h3);
    wr(DISTRIBUTED_DMA_IDX_SW_REQ, 32'h5A);
    wait_tc(3);
    rd(DISTRIBUTED_DMA_IDX_ADDRESS, 32'h0D);
    rd(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'h0F);
    rd(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'h0);
    chk(32'(xfer.request), 32'h0);
  endtask
  task automatic t_reload();
    wr(DISTRIBUTED_DMA_IDX_MODE, 32'h58);
    wr(DISTRIBUTED_DMA_IDX_ADDRESS, 32'h100);
    wr(DISTRIBUTED_DMA_IDX_COUNT, 32'h4);
    wide <= 1'b1;
    card_req <= 1'b1;
    wait_tc(2);
    rd(DISTRIBUTED_DMA_IDX_ADDRESS, 32'h100);
    rd(DISTRIBUTED_DMA_IDX_COUNT, 32'h4);
  endtask
  task automatic t_clear();
    wr(DISTRIBUTED_DMA_IDX_CLEAR, 32'h0);
    rd(DISTRIBUTED_DMA_IDX_MODE, 32'h0);
    rd(DISTRIBUTED_DMA_IDX_MASK, 32'h1);
    rd(DISTRIBUTED_DMA_IDX_CMD_STAT, 32'h0);
    rd(DISTRIBUTED_DMA_IDX_ADDRESS, 32'h0);
  endtask
  task automatic t_removal();
    wr(DISTRIBUTED_DMA_IDX_MODE, 32'h04);
    card_req <= 1'b1;
    wr(DISTRIBUTED_DMA_IDX_MASK, 32'h0);
    @(posedge mclk);
    chk(32'(xfer.request), 32'h1);
    card_pres <= 1'b0;
    repeat (2) @(posedge mclk);
    chk(32'(xfer.request), 32'h0);
    card_req <= 1'b0;
    rd(DISTRIBUTED_DMA_IDX_MASK, 32'h1);
    card_pres <= 1'b1;
    wr(DISTRIBUTED_DMA_IDX_MASK, 32'h0);
    rd(DISTRIBUTED_DMA_IDX_MASK, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_reserved();
    t_card();
    t_block();
    t_reload();
    wide <= 1'b0;
    t_clear();
    t_removal();
    test_done();
  end
  // hang guard, far beyond the few hundred cycles of the run
  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    test_done();
  end
endmodule
